// *** rtl/dbg_bc_consts.svh ***
/*
 Offsets, reset values and field positions for the comparator B/C and trace readout block.
 Assumes inclusion by bare name from design files under rtl/.
*/
// How it works
// - Power-on or non-end-run reset clears comparator B, C and trace registers.
// - End-trace reset with debug enabled and no begin-trigger keeps registers unchanged.
// - Comparator B high byte matches address bits 15:8; ignored in full mode.
// - Comparator B low byte matches address bits 7:0 exactly.
// - Comparator C high byte matches address bits 15:8 exactly.
// - Comparator C low byte matches address bits 7:0 exactly.
// - Trace high byte register returns bits 15:8 of current trace word.
// - In event-only modes the trace high byte reads zero.
// - Trace low byte returns bits 7:0; each read advances the read pointer unless the trace buffer is empty.
// - Trace high and low byte registers are read-only; writes are ignored.
`ifndef DBG_BC_CONSTS_SVH
`define DBG_BC_CONSTS_SVH

`define IDX_CMP_B_HIGH 16'h3012
`define IDX_CMP_B_LOW 16'h3013
`define IDX_CMP_C_HIGH 16'h3014
`define IDX_CMP_C_LOW 16'h3015
`define IDX_TRACE_HIGH 16'h3016
`define IDX_TRACE_LOW 16'h3017
`define IDX_BITS 12
`define REG_RESET 8'h00
`define TRACE_DEPTH 8
`define TRACE_PTR_W 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** rtl/dbg_bc_pkg.sv ***
/*
 Types shared by the comparator B/C and trace readout block.
 Assumes the constants header is compiled alongside.
*/
package dbg_bc_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_e;
   typedef enum logic [1:0] {RD_IDLE, RD_RESP} rd_state_e;
endpackage

// *** rtl/addr_match.sv ***
/*
 One 16-bit address comparator built from a high and a low match byte.
 Assumes the match bytes and the address are synchronous to the caller's clock.
*/
`timescale 1ns/10ps
`default_nettype none
module addr_match
   import dbg_bc_pkg::*;
(
   // Match values
   input wire logic [7:0] match_high,
   input wire logic [7:0] match_low,
   input wire logic use_high,
   // Bus
   input wire logic [15:0] addr,
   // Result
   output logic hit
);
   // A bit set requires a one on the address, a cleared bit requires a zero; the high byte counts only while use_high is set.
   assign hit = ((addr[15:8] == match_high) | ~use_high) & (addr[7:0] == match_low);
endmodule // addr_match
`default_nettype wire

// *** rtl/dbg_bc_trace.sv ***
/*
 Comparator B and C match registers and the trace word read port, behind an AXI4-Lite slave.
 Assumes trace words are pushed by an external fill path and that all inputs share core_clk.
 Register byte address is four times the register index.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dbg_bc_consts.svh"
module dbg_bc_trace
   import dbg_bc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Reset cause
   input wire logic end_trace_reset,
   input wire logic debug_unit_enable,
   input wire logic begin_trigger_sel,
   // Mode
   input wire logic full_mode,
   input wire logic event_only_mode,
   // Processor address bus
   input wire logic [15:0] cpu_addr,
   // Trace fill path
   input wire logic trace_push,
   input wire logic [15:0] trace_word,
   // AXI4-Lite write
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Comparator results
   output logic match_b_hit,
   output logic match_c_hit
);

   ////////////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      byte_t match_b_upper_bits;
      byte_t match_b_lower_bits;
      byte_t match_c_upper_bits;
      byte_t match_c_lower_bits;
      word_t [`TRACE_DEPTH-1:0] mem;
      logic [`TRACE_PTR_W-1:0] rd_ptr;
      logic [`TRACE_PTR_W-1:0] wr_ptr;
      logic [`TRACE_PTR_W:0] count;
      logic aw_got;
      logic w_got;
      logic [15:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      wr_state_e wst;
      rd_state_e rst;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic hit_b;
      logic hit_c;
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic rvalid;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic hit_b_w;
   logic hit_c_w;

   ////////////////////////////////////////////////////////////////////////////////////////
   addr_match u_match_b
   (
      .match_high(st_q.match_b_upper_bits),
      .match_low(st_q.match_b_lower_bits),
      .use_high(~full_mode),
      .addr(cpu_addr),
      .hit(hit_b_w)
   );

   addr_match u_match_c
   (
      .match_high(st_q.match_c_upper_bits),
      .match_low(st_q.match_c_lower_bits),
      .use_high(1'b1),
      .addr(cpu_addr),
      .hit(hit_c_w)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [`IDX_BITS-1:0] reg_index(input logic [15:0] a);
      reg_index = a[`IDX_BITS+1:2];
   endfunction

   always_comb
   begin
      logic [`IDX_BITS-1:0] widx;
      logic [`IDX_BITS-1:0] ridx;
      logic pop;
      logic push;
      word_t head;
      widx = '0;
      ridx = '0;
      pop = 1'b0;
      push = 1'b0;
      head = '0;
      st_d = st_q;
      st_d.hit_b = hit_b_w;
      st_d.hit_c = hit_c_w;
      head = st_q.mem[st_q.rd_ptr];

      // Write channel: address and data may arrive in either order.
      unique case (st_q.wst)
         WR_IDLE:
         begin
            if (s_axi_awvalid && !st_q.aw_got)
            begin
               st_d.aw_got = 1'b1;
               st_d.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_q.w_got)
            begin
               st_d.w_got = 1'b1;
               st_d.wdata = s_axi_wdata;
               st_d.wstrb = s_axi_wstrb;
            end
            if (st_q.aw_got && st_q.w_got)
            begin
               widx = reg_index(st_q.awaddr);
               st_d.bresp = `RESP_OKAY;
               // Only whole-byte lane 0 writes change a register.
               if (st_q.wstrb[0])
               begin
                  unique case (widx)
                     `IDX_BITS'(`IDX_CMP_B_HIGH):
                     begin
                        st_d.match_b_upper_bits = st_q.wdata[7:0];
                     end
                     `IDX_BITS'(`IDX_CMP_B_LOW):
                     begin
                        st_d.match_b_lower_bits = st_q.wdata[7:0];
                     end
                     `IDX_BITS'(`IDX_CMP_C_HIGH):
                     begin
                        st_d.match_c_upper_bits = st_q.wdata[7:0];
                     end
                     `IDX_BITS'(`IDX_CMP_C_LOW):
                     begin
                        st_d.match_c_lower_bits = st_q.wdata[7:0];
                     end
                     `IDX_BITS'(`IDX_TRACE_HIGH), `IDX_BITS'(`IDX_TRACE_LOW):
                     begin
                        // The trace bytes are read-only, so a write is accepted and dropped.
                        st_d.bresp = `RESP_OKAY;
                     end
                     default:
                     begin
                        st_d.bresp = `RESP_SLVERR;
                     end
                  endcase
               end
               st_d.aw_got = 1'b0;
               st_d.w_got = 1'b0;
               st_d.wst = WR_RESP;
            end
         end
         WR_RESP:
         begin
            if (s_axi_bready)
               st_d.wst = WR_IDLE;
         end
         default:
         begin
            st_d.wst = WR_IDLE;
         end
      endcase

      // Read channel.
      unique case (st_q.rst)
         RD_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               ridx = reg_index(s_axi_araddr);
               st_d.rdata = '0;
               st_d.rresp = `RESP_OKAY;
               unique case (ridx)
                  `IDX_BITS'(`IDX_CMP_B_HIGH):
                  begin
                     st_d.rdata[7:0] = st_q.match_b_upper_bits;
                  end
                  `IDX_BITS'(`IDX_CMP_B_LOW):
                  begin
                     st_d.rdata[7:0] = st_q.match_b_lower_bits;
                  end
                  `IDX_BITS'(`IDX_CMP_C_HIGH):
                  begin
                     st_d.rdata[7:0] = st_q.match_c_upper_bits;
                  end
                  `IDX_BITS'(`IDX_CMP_C_LOW):
                  begin
                     st_d.rdata[7:0] = st_q.match_c_lower_bits;
                  end
                  `IDX_BITS'(`IDX_TRACE_HIGH):
                  begin
                     st_d.rdata[7:0] = event_only_mode ? `REG_RESET : head[15:8];
                  end
                  `IDX_BITS'(`IDX_TRACE_LOW):
                  begin
                     st_d.rdata[7:0] = head[7:0];
                     // Reading the low byte moves on, so the high byte must be read first.
                     pop = (st_q.count != '0);
                  end
                  default:
                  begin
                     st_d.rresp = `RESP_SLVERR;
                  end
               endcase
               st_d.rst = RD_RESP;
            end
         end
         RD_RESP:
         begin
            if (s_axi_rready)
               st_d.rst = RD_IDLE;
         end
         default:
         begin
            st_d.rst = RD_IDLE;
         end
      endcase

      // A full buffer drops new words rather than overwrite unread ones.
      push = trace_push && (st_q.count != (`TRACE_PTR_W+1)'(`TRACE_DEPTH));
      if (push)
      begin
         st_d.mem[st_q.wr_ptr] = trace_word;
         st_d.wr_ptr = st_q.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         st_d.mem[st_q.rd_ptr] = push && (st_q.wr_ptr == st_q.rd_ptr) ? trace_word : '0;
         st_d.rd_ptr = st_q.rd_ptr + 1'b1;
      end
      st_d.count = st_q.count + (`TRACE_PTR_W+1)'(push) - (`TRACE_PTR_W+1)'(pop);

      // Handshake outputs are flip-flops, so they are worked out from the next state.
      st_d.awready = (st_d.wst == WR_IDLE) && !st_d.aw_got;
      st_d.wready = (st_d.wst == WR_IDLE) && !st_d.w_got;
      st_d.arready = (st_d.rst == RD_IDLE);
      st_d.bvalid = (st_d.wst == WR_RESP);
      st_d.rvalid = (st_d.rst == RD_RESP);
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         if (end_trace_reset && debug_unit_enable && !begin_trigger_sel)
         begin
            // Debug state survives so trace taken up to reset can be read out.
            st_q <= st_q;
            st_q.aw_got <= 1'b0;
            st_q.w_got <= 1'b0;
            st_q.wst <= WR_IDLE;
            st_q.rst <= RD_IDLE;
            st_q.bvalid <= 1'b0;
            st_q.rvalid <= 1'b0;
         end
         else
         begin
            st_q <= '0;
         end
         // Either way the bus leaves reset idle and ready for the first request.
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign match_b_hit = st_q.hit_b;
   assign match_c_hit = st_q.hit_c;
endmodule // dbg_bc_trace
`default_nettype wire

// *** sim/dbg_bc_trace_assertions.sv ***
/*
 Checker for the comparator and trace readout block.
 Sees only the top module ports and is bound to every instance of it.
*/
`timescale 1ns/10ps
`default_nettype none
module dbg_bc_trace_assertions
(
   // Clock, reset and mode
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic event_only_mode,
   // Register bus
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   a_high_zero: assert property (s_axi_arvalid && s_axi_arready && event_only_mode
      && s_axi_araddr == 16'hc058 |=> s_axi_rdata == 32'h0) else $error("high byte not zero");
   a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_reset_idle: assert property (disable iff (1'b0) !nrst |=> !s_axi_rvalid
      && !s_axi_bvalid) else $error("bus busy after reset");
endmodule // dbg_bc_trace_assertions

bind dbg_bc_trace dbg_bc_trace_assertions dbg_bc_trace_assertions_i (.core_clk, .nrst,
   .event_only_mode, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// *** sim/cpu_side_model.sv ***
/*
 Processor side model: address bus and trace fill path.
 Driven by tasks that the bench calls right after a core_clk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model
(
   // Clock
   input wire logic core_clk,
   // Address bus and fill path
   output var logic [15:0] cpu_addr,
   output var logic trace_push,
   output var logic [15:0] trace_word
);
   initial {cpu_addr, trace_push, trace_word} = 33'h0;
   task put(input logic [15:0] a);
      @(posedge core_clk);
      cpu_addr <= a;
   endtask
   task push(input logic [15:0] w);
      @(posedge core_clk);
      trace_push <= 1'b1;
      trace_word <= w;
      @(posedge core_clk);
      trace_push <= 1'b0;
      // The word is not held after the pulse, so a late sample is caught.
      trace_word <= ~w;
   endtask
endmodule // cpu_side_model
`default_nettype wire

// *** sim/test_dbg_bc_trace.sv ***
/*
 Bench for the comparator and trace readout block.
 Assumes register byte addresses are four times the register index.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dbg_bc_consts.svh"
module test_dbg_bc_trace
   import dbg_bc_pkg::*;
;
   logic core_clk = 1'b0, nrst = 1'b0, end_trace_reset = 1'b0, debug_unit_enable = 1'b0;
   logic begin_trigger_sel = 1'b0, full_mode = 1'b0, event_only_mode = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, cpu_addr, trace_word, a;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, trace_push, match_b_hit, match_c_hit;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors = 0, checks_done = 0, cyc = 0;
   byte_t v [4];
   word_t w [3];
   always #5 core_clk = ~core_clk;
   cpu_side_model cpu_side_model_i (.core_clk, .cpu_addr, .trace_push, .trace_word);
   dbg_bc_trace dbg_bc_trace_i (.core_clk, .nrst, .end_trace_reset, .debug_unit_enable,
      .begin_trigger_sel, .full_mode, .event_only_mode, .cpu_addr, .trace_push, .trace_word,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .match_b_hit, .match_c_hit);
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task complete_run;
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function logic [15:0] ad(input int i);
      return (`IDX_CMP_B_HIGH + 16'(i)) << 2;
   endfunction
   function logic hitf(input byte_t h, input byte_t l, input logic [15:0] x, input logic f);
      return (f || x[15:8] == h) && x[7:0] == l;
   endfunction
   task wr(input logic [15:0] ka, input byte_t d, input logic [3:0] s, input logic [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr <= ka;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      fork
         begin
            do @(posedge core_clk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge core_clk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      // A late bready makes the slave hold its answer.
      repeat ($urandom % 3) @(posedge core_clk);
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task rd(input logic [15:0] ka, input byte_t e, input logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= ka;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      // A late rready makes the slave hold its answer.
      repeat ($urandom % 3) @(posedge core_clk);
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, e});
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   task rst(input logic et, input logic en, input logic bg, input int n);
      @(posedge core_clk);
      nrst <= 1'b0;
      end_trace_reset <= et;
      debug_unit_enable <= en;
      begin_trigger_sel <= bg;
      repeat (n) @(posedge core_clk);
      nrst <= 1'b1;
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         complete_run;
      end
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h103f));
      rst(1'b0, 1'b0, 1'b0, 16);
      for (int i = 0; i < 6; i++)
         rd(ad(i), `REG_RESET, `RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         v[i] = byte_t'($urandom);
         wr(ad(i), v[i], 4'h1, `RESP_OKAY);
         // Lane 0 clear must leave the byte alone.
         wr(ad(i), ~v[i], 4'he, `RESP_OKAY);
         rd(ad(i), v[i], `RESP_OKAY);
      end
      wr(ad(6), 8'h5a, 4'h1, `RESP_SLVERR);
      rd(ad(6), 8'h00, `RESP_SLVERR);
      for (int i = 0; i < 24; i++)
      begin
         a = (i % 3 == 0) ? {v[0] ^ 8'(i[2]), v[1]} : (i % 3 == 1) ? {v[2], v[3]} : 16'($urandom);
         cpu_side_model_i.put(a);
         full_mode <= i[0];
         repeat (2) @(posedge core_clk);
         chk({31'h0, match_b_hit}, {31'h0, hitf(v[0], v[1], a, full_mode)});
         chk({31'h0, match_c_hit}, {31'h0, hitf(v[2], v[3], a, 1'b0)});
      end
      for (int i = 0; i < 3; i++)
      begin
         w[i] = word_t'($urandom);
         cpu_side_model_i.push(w[i]);
      end
      wr(ad(4), 8'hff, 4'h1, `RESP_OKAY);
      wr(ad(5), 8'hff, 4'h1, `RESP_OKAY);
      for (int i = 0; i < 3; i++)
      begin
         rd(ad(4), w[i][15:8], `RESP_OKAY);
         rd(ad(5), w[i][7:0], `RESP_OKAY);
      end
      rd(ad(5), 8'h00, `RESP_OKAY);
      event_only_mode <= 1'b1;
      cpu_side_model_i.push(w[0]);
      cpu_side_model_i.push(w[1]);
      rd(ad(4), 8'h00, `RESP_OKAY);
      rd(ad(5), w[0][7:0], `RESP_OKAY);
      rd(ad(5), w[1][7:0], `RESP_OKAY);
      event_only_mode <= 1'b0;
      cpu_side_model_i.push(w[2]);
      rst(1'b1, 1'b1, 1'b0, 2);
      rd(ad(0), v[0], `RESP_OKAY);
      rd(ad(4), w[2][15:8], `RESP_OKAY);
      rd(ad(5), w[2][7:0], `RESP_OKAY);
      cpu_side_model_i.push(w[0]);
      rst(1'b1, 1'b1, 1'b1, 2);
      rd(ad(3), `REG_RESET, `RESP_OKAY);
      rd(ad(5), `REG_RESET, `RESP_OKAY);
      complete_run;
   end
endmodule // test_dbg_bc_trace
`default_nettype wire
